// ==== rcoc_map.svh ====
// Register map, field positions and constants of the reference clock control.
// Included by every module file of the block; holds definitions only.
`ifndef RCOC_MAP_SVH
`define RCOC_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define RCOC_ADDR_W 8
`define RCOC_CTRL_OFS 8'h00

// ---------------------------------------------------------------
// Control word fields
// ---------------------------------------------------------------
`define RCOC_DIV_HI 30
`define RCOC_DIV_LO 16
`define RCOC_ON_BIT 15
`define RCOC_STOP_IDLE_BIT 13
`define RCOC_OE_BIT 12
`define RCOC_RUN_SLEEP_BIT 11
`define RCOC_SW_BIT 9
`define RCOC_ACT_BIT 8
`define RCOC_SEL_HI 3
`define RCOC_SEL_LO 0
`define RCOC_RSVD_MASK 32'h800044F0

// ---------------------------------------------------------------
// Values
// ---------------------------------------------------------------
`define RCOC_SEL_SYS 4'h0
`define RCOC_SEL_PB 4'h1
`define RCOC_DIV_ZERO 15'h0000
`define RCOC_DIV_ONE 15'h0001
`define RCOC_WORD_ZERO 32'h00000000

`endif

// ==== rcoc_pkg.sv ====
// Types shared by the reference clock control modules.
// Assumes rcoc_map.svh is compiled alongside.
package rcoc_pkg;

	// ---------------------------------------------------------------
	// Software control fields
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [14:0] div;
		logic on;
		logic stopIdle;
		logic oe;
		logic runSleep;
		logic swPend;
		logic [3:0] sel;
	} rcoc_ctrl_t;

	// ---------------------------------------------------------------
	// Module states
	// ---------------------------------------------------------------
	typedef struct packed {
		rcoc_ctrl_t ctrl;
		logic [14:0] actDiv;
		logic active;
		logic rdValid;
		logic [31:0] rdData;
		logic pinOut;
		logic pinOe;
	} rcoc_state_t;

	typedef struct packed {
		logic lvl;
		logic rise;
	} rcoc_edge_state_t;

	typedef struct packed {
		logic [14:0] cnt;
		logic clkOut;
	} rcoc_div_state_t;

endpackage

// ==== rcoc_edge_sel.sv ====
// Source selection and rising edge detection for the reference divider.
// Assumes all source levels are synchronous to clk.
`timescale 1ns/10ps
`include "rcoc_map.svh"

module rcoc_edge_sel import rcoc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Sources
	input wire logic [15:0] srcLevels,
	input wire logic [3:0] sel,
	// Selected source
	output logic srcLevel,
	output logic srcRise
);

	rcoc_edge_state_t s_r;
	rcoc_edge_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.lvl = srcLevels[sel];
		s_nxt.rise = srcLevels[sel] & ~s_r.lvl;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign srcLevel = s_r.lvl;
	assign srcRise = s_r.rise;

endmodule // rcoc_edge_sel

// ==== rcoc_divider.sv ====
// Reference clock divider: output toggles every divisor rising source edges.
// Assumes the divisor is only changed while atBoundary is high.
`timescale 1ns/10ps
`include "rcoc_map.svh"

module rcoc_divider import rcoc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Control
	input wire logic run,
	input wire logic [14:0] divisor,
	// Source
	input wire logic srcLevel,
	input wire logic srcRise,
	// Output
	output logic clkOut,
	output logic atBoundary
);

	rcoc_div_state_t s_r;
	rcoc_div_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (!run) begin
			s_nxt.cnt = `RCOC_DIV_ZERO;
			s_nxt.clkOut = 1'h0;
		end else if (divisor == `RCOC_DIV_ZERO) begin
			// Divisor zero passes the source straight through
			s_nxt.cnt = `RCOC_DIV_ZERO;
			s_nxt.clkOut = srcLevel;
		end else if (srcRise) begin
			if (s_r.cnt >= divisor - `RCOC_DIV_ONE) begin
				s_nxt.cnt = `RCOC_DIV_ZERO;
				s_nxt.clkOut = ~s_r.clkOut;
			end else begin
				s_nxt.cnt = s_r.cnt + `RCOC_DIV_ONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign clkOut = s_r.clkOut;
	// Low phase at count zero: a new period length starts cleanly here
	assign atBoundary = ~s_r.clkOut & (s_r.cnt == `RCOC_DIV_ZERO);

endmodule // rcoc_divider

// ==== rcoc_top.sv ====
// Reference clock output control: control register, divider handshake,
// idle and sleep gating, and the output pin driver.
// Assumes a simple strobe register port and synchronous source levels.
`timescale 1ns/10ps
`include "rcoc_map.svh"

module rcoc_top import rcoc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [`RCOC_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// Power modes
	input wire logic idleMode,
	input wire logic sleepMode,
	// Reference sources
	input wire logic [15:0] srcLevels,
	// Output pin and clock request
	output logic refClkOut,
	output logic refClkOutOe,
	output logic refActive
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	rcoc_state_t st_r;
	rcoc_state_t st_nxt;

	logic srcLevel;
	logic srcRise;
	logic divOut;
	logic atBoundary;
	logic run;
	logic sleepAllowed;
	logic ctrlWr;
	logic ctrlRd;
	logic [31:0] ctrlWord;
	logic [14:0] wrDiv;

	// ---------------------------------------------------------------
	// Source selection and divider
	// ---------------------------------------------------------------
	rcoc_edge_sel u_edge (
		.clk(clk),
		.sys_rst(sys_rst),
		.srcLevels(srcLevels),
		.sel(st_r.ctrl.sel),
		.srcLevel(srcLevel),
		.srcRise(srcRise)
	);

	rcoc_divider u_div (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(run),
		.divisor(st_r.actDiv),
		.srcLevel(srcLevel),
		.srcRise(srcRise),
		.clkOut(divOut),
		.atBoundary(atBoundary)
	);

	// ---------------------------------------------------------------
	// Run gating
	// ---------------------------------------------------------------
	// Sources 0000 and 0001 stop in Sleep themselves, so the bit has no say
	assign sleepAllowed = st_r.ctrl.runSleep
		& (st_r.ctrl.sel != `RCOC_SEL_SYS)
		& (st_r.ctrl.sel != `RCOC_SEL_PB);

	// Halting is immediate; a high phase may be cut short on entry
	assign run = st_r.ctrl.on
		& ~(idleMode & st_r.ctrl.stopIdle)
		& ~(sleepMode & ~sleepAllowed);

	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	assign ctrlWr = regWr & (regAddr == `RCOC_CTRL_OFS);
	assign ctrlRd = regRd & (regAddr == `RCOC_CTRL_OFS);
	assign wrDiv = regWrData[`RCOC_DIV_HI:`RCOC_DIV_LO];

	always_comb begin
		ctrlWord = `RCOC_WORD_ZERO;
		ctrlWord[`RCOC_DIV_HI:`RCOC_DIV_LO] = st_r.ctrl.div;
		ctrlWord[`RCOC_ON_BIT] = st_r.ctrl.on;
		ctrlWord[`RCOC_STOP_IDLE_BIT] = st_r.ctrl.stopIdle;
		ctrlWord[`RCOC_OE_BIT] = st_r.ctrl.oe;
		ctrlWord[`RCOC_RUN_SLEEP_BIT] = st_r.ctrl.runSleep;
		ctrlWord[`RCOC_SW_BIT] = st_r.ctrl.swPend;
		ctrlWord[`RCOC_ACT_BIT] = st_r.active;
		ctrlWord[`RCOC_SEL_HI:`RCOC_SEL_LO] = st_r.ctrl.sel;
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;

		// Divider handshake: load at a clean boundary, then drop the flag
		if (st_r.ctrl.swPend && atBoundary) begin
			st_nxt.actDiv = st_r.ctrl.div;
			st_nxt.ctrl.swPend = 1'h0;
		end

		if (ctrlWr) begin
			st_nxt.ctrl.div = wrDiv;
			st_nxt.ctrl.on = regWrData[`RCOC_ON_BIT];
			st_nxt.ctrl.stopIdle = regWrData[`RCOC_STOP_IDLE_BIT];
			st_nxt.ctrl.oe = regWrData[`RCOC_OE_BIT];
			st_nxt.ctrl.runSleep = regWrData[`RCOC_RUN_SLEEP_BIT];
			st_nxt.ctrl.sel = regWrData[`RCOC_SEL_HI:`RCOC_SEL_LO];
			// Disabled: divider takes effect at once
			if (!st_r.ctrl.on) begin
				st_nxt.actDiv = wrDiv;
			end
			// A new request wins over the hardware clear in the same cycle
			if (regWrData[`RCOC_SW_BIT]) begin
				st_nxt.ctrl.swPend = 1'h1;
			end
		end

		// Request stays active until the output has settled low
		st_nxt.active = st_r.ctrl.on | divOut;

		// Read data stand for exactly one cycle
		st_nxt.rdValid = ctrlRd;
		st_nxt.rdData = ctrlRd ? ctrlWord : `RCOC_WORD_ZERO;

		st_nxt.pinOe = st_r.ctrl.oe & st_r.ctrl.on;
		st_nxt.pinOut = st_r.ctrl.oe & divOut;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign regRdData = st_r.rdData;
	assign refClkOut = st_r.pinOut;
	assign refClkOutOe = st_r.pinOe;
	assign refActive = st_r.active;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking

	default disable iff (sys_rst);

	chk_rsvd_zero: assert property (
		st_r.rdValid |-> ((st_r.rdData & `RCOC_RSVD_MASK) == `RCOC_WORD_ZERO)
	) else $error("reserved control bits read non-zero");

	chk_div_hold: assert property (
		(st_r.ctrl.on && !st_r.ctrl.swPend && !(ctrlWr && regWrData[`RCOC_SW_BIT]))
		|=> $stable(st_r.actDiv)
	) else $error("active divider changed without a switch request");

	chk_div_load: assert property (
		(st_r.ctrl.swPend && atBoundary && !ctrlWr)
		|=> (st_r.actDiv == $past(st_r.ctrl.div)) && !st_r.ctrl.swPend
	) else $error("pending divider not loaded at boundary");

	chk_div_field: assert property (
		(ctrlWr && !st_r.ctrl.on)
		|=> (st_r.actDiv == $past(wrDiv)) && (st_r.ctrl.div == $past(wrDiv))
	) else $error("divider field not taken while disabled");

	chk_off_stop: assert property (
		!st_r.ctrl.on |=> !divOut ##1 !st_r.pinOut
	) else $error("output toggles while generator disabled");

	chk_idle_halt: assert property (
		(st_r.ctrl.on && idleMode && st_r.ctrl.stopIdle) |=> !divOut
	) else $error("generator kept running in idle with stop bit set");

	chk_sleep_sys: assert property (
		(sleepMode && st_r.ctrl.sel == `RCOC_SEL_SYS) |-> !run
	) else $error("run-in-sleep honoured for an ignored source");

	chk_sleep_run: assert property (
		(sleepMode && !idleMode && st_r.ctrl.on && sleepAllowed) |-> run
	) else $error("generator stopped in sleep with run-in-sleep set");

	chk_sleep_pb: assert property (
		(sleepMode && st_r.ctrl.sel == `RCOC_SEL_PB) |-> !run
	) else $error("run-in-sleep honoured for the second ignored source");

	chk_idle_run: assert property (
		(st_r.ctrl.on && idleMode && !st_r.ctrl.stopIdle && !sleepMode) |-> run
	) else $error("generator halted in idle without the stop bit");

	chk_pin_drive: assert property (
		##1 (refClkOutOe == $past(st_r.ctrl.oe && st_r.ctrl.on))
		&& (refClkOut == $past(st_r.ctrl.oe && divOut))
	) else $error("output pin does not follow output enable");

	chk_read_flags: assert property (
		st_r.rdValid |-> (st_r.rdData[`RCOC_SW_BIT] == $past(st_r.ctrl.swPend))
		&& (st_r.rdData[`RCOC_ACT_BIT] == $past(st_r.active))
	) else $error("status flags misreported on read");

	chk_active_on: assert property (
		st_r.ctrl.on |=> st_r.active
	) else $error("request not active while enabled");

	chk_read_once: assert property (
		!st_r.rdValid |-> (regRdData == `RCOC_WORD_ZERO)
	) else $error("read data outside the answer cycle");

	cov_switch: cover property (
		st_r.ctrl.swPend && st_r.ctrl.on ##[1:200] !st_r.ctrl.swPend
	);

	cov_pin_toggle: cover property (
		refClkOutOe && refClkOut ##[1:100] refClkOutOe && !refClkOut
	);

	cov_idle_stop: cover property (
		st_r.ctrl.on && st_r.ctrl.stopIdle && idleMode && divOut ##1 !divOut
	);

	cov_sleep_run: cover property (
		sleepMode && sleepAllowed && st_r.ctrl.on ##[1:100] divOut
	);

endmodule // rcoc_top

// ==== rcoc_test.sv ====
// Self-checking bench for the reference clock output control block.
// Assumes rcoc_top with its map header and package compiled alongside.
`timescale 1ns/10ps
`include "rcoc_map.svh"

module rcoc_test import rcoc_pkg::*; ;
	logic clk;
	logic sysRst;
	logic [7:0] regAddr;
	logic [31:0] regWrData;
	logic [31:0] regRdData;
	logic regWr;
	logic regRd;
	logic idleMode;
	logic sleepMode;
	logic [15:0] srcLevels;
	logic refClkOut;
	logic refClkOutOe;
	logic refActive;
	logic prevOut;
	logic [1:0] srcCnt;
	logic [31:0] rdVal;
	int errors;
	int nCompared;
	int cycles;
	int nRise;
	int sinceRise;
	int lastGap;

	rcoc_top dut (
		.clk(clk), .sys_rst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .idleMode(idleMode),
		.sleepMode(sleepMode), .srcLevels(srcLevels), .refClkOut(refClkOut),
		.refClkOutOe(refClkOutOe), .refActive(refActive)
	);

	// ---------------------------------------------------------------
	// Clock, sources and watchers
	// ---------------------------------------------------------------
	initial clk = 1'b0;
	always #50 clk = ~clk;

	// All sources share one pattern: a period of 8 clocks
	always @(posedge clk) begin
		srcCnt <= srcCnt + 2'h1;
		if (srcCnt == 2'h3) srcLevels <= ~srcLevels;
	end

	always @(posedge clk) begin
		prevOut <= refClkOut;
		if (refClkOut === 1'b1 && prevOut === 1'b0) begin
			nRise <= nRise + 1;
			lastGap <= sinceRise;
			sinceRise <= 1;
		end else sinceRise <= sinceRise + 1;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask

	function automatic logic [31:0] word(logic [14:0] div, logic on, logic stopIdle, logic oe,
		logic runSleep, logic sw, logic [3:0] sel);
		return {1'b0, div, on, 1'b0, stopIdle, oe, runSleep, 1'b0, sw, 1'b0, 4'h0, sel};
	endfunction

	// Stop first so select and divider change only while idle
	task automatic cfg(input logic [31:0] w);
		wr(8'h00, 32'h00000000);
		repeat (6) @(posedge clk);
		wr(8'h00, w & 32'hFFFF7FFF);
		wr(8'h00, w);
	endtask

	task automatic run_chk(input string name, input logic exp);
		int n0;
		// Let the two-stage output pipeline settle before counting
		repeat (4) @(posedge clk);
		n0 = nRise;
		repeat (80) @(posedge clk);
		#1 check(name, 32'(nRise != n0), 32'(exp));
	endtask

	task automatic end_of_test();
		$display("compared %0d errors %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_fields();
		rd(8'h00, rdVal);
		check("ctrl reset", rdVal, 32'h00000000);
		check("active reset", 32'(refActive), 32'h0);
		wr(8'h00, 32'hFFFF7DFF);
		rd(8'h00, rdVal);
		check("ctrl fields", rdVal, 32'h7FFF380F);
		wr(8'h04, 32'hFFFFFFFF);
		rd(8'h04, rdVal);
		check("unmapped", rdVal, 32'h00000000);
		rd(8'h00, rdVal);
		check("ctrl kept", rdVal, 32'h7FFF380F);
	endtask

	task automatic t_divider();
		int i;
		cfg(word(15'h0001, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h2));
		repeat (120) @(posedge clk);
		check("period div1", lastGap, 32'h10);
		check("pin oe", 32'(refClkOutOe), 32'h1);
		rd(8'h00, rdVal);
		check("active bit", 32'(rdVal[8]), 32'h1);
		wr(8'h00, word(15'h0002, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h2));
		repeat (120) @(posedge clk);
		check("held divider", lastGap, 32'h10);
		// Read straight after the request so the flag is seen before any boundary
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= 8'h00;
		regWrData <= word(15'h0002, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'h2);
		@(posedge clk);
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 rdVal = regRdData;
		check("switch busy", 32'(rdVal[9]), 32'h1);
		for (i = 0; i < 40 && rdVal[9] !== 1'b0; i++) rd(8'h00, rdVal);
		check("switch done", 32'(rdVal[9]), 32'h0);
		repeat (120) @(posedge clk);
		check("period div2", lastGap, 32'h20);
		cfg(word(15'h0000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h2));
		repeat (120) @(posedge clk);
		check("period bypass", lastGap, 32'h08);
	endtask

	task automatic t_pin_idle();
		cfg(word(15'h0001, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2));
		run_chk("pin off", 1'b0);
		check("oe off", 32'(refClkOutOe), 32'h0);
		check("active on", 32'(refActive), 32'h1);
		cfg(word(15'h0001, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h2));
		@(posedge clk) idleMode <= 1'b1;
		run_chk("idle stop", 1'b0);
		@(posedge clk) idleMode <= 1'b0;
		run_chk("idle resume", 1'b1);
		cfg(word(15'h0001, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h2));
		@(posedge clk) idleMode <= 1'b1;
		run_chk("idle run", 1'b1);
		@(posedge clk) idleMode <= 1'b0;
	endtask

	// Sleep cases: run-in-sleep, select, expected running
	task automatic t_sleep();
		logic [5:0] tbl [4];
		int i;
		// Sources 0 and 1 always stop in Sleep, whatever run-in-sleep says
		tbl = '{6'h32, 6'h02, 6'h11, 6'h10};
		for (i = 0; i < 4; i++) begin
			cfg(word(15'h0001, 1'b1, 1'b0, 1'b1, tbl[i][4], 1'b0, tbl[i][3:0]));
			@(posedge clk) sleepMode <= 1'b1;
			run_chk("sleep", tbl[i][5]);
			@(posedge clk) sleepMode <= 1'b0;
		end
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{errors, nCompared, cycles, nRise, sinceRise, lastGap} = '0;
		{regWr, regRd, idleMode, sleepMode, prevOut} = '0;
		regAddr = 8'h00;
		regWrData = 32'h00000000;
		srcLevels = 16'h0000;
		srcCnt = 2'h0;
		sysRst = 1'b1;
		repeat (4) @(posedge clk);
		sysRst <= 1'b0;
		t_fields();
		t_divider();
		t_pin_idle();
		t_sleep();
		end_of_test();
	end
endmodule // rcoc_test
